// ### hw/sst_top.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Contract
// - Supply or internal-supply fault forces power-down above every other transition
// - Init timer expires after 600 ms and raises the init time-out event
// - Transition delay holds within 20 percent, latency adds at most 30 us
// - Sleep and standby entry timed by the transition delay setting
// - Init entry within 150 us, or 250 us from standby, failsafe, interrupted standby; the code also takes 250 us from an interrupted sleep entry
// - After first supply connection reach init within 2 ms, typically 0.4 ms
// - Force artificial fault on each selected comparator and check its reaction; with the single bit set the code stops after the lowest selected one
// - One pass flag after a run; only basic comparator function is checked
// - Comparator-only mode forces the fault shorter than the deglitch time
// - Only selected comparators tested, stepped in fixed ascending order
// - Interrupt event when a comparator-only run completes
// - Full-path mode forces the fault longer than the deglitch time
// - Device reports results for comparator-only and full-path areas only
// - Safe-state control watchdog and toggle monitor comparators are testable too
// - Stay in failsafe at least 1 s after a thermal shutdown
// - Go bit stays set while testing, hardware clears it with an interrupt event
// - Pick bit cleared only on pass, kept set on failure
module sst_top #(
  parameter int N_CMP = sst_pkg::N_CMP,
  parameter int INIT_CYC = sst_pkg::INIT_CYC,
  parameter int FS_CYC = sst_pkg::FS_CYC,
  parameter int FS_TSD_CYC = sst_pkg::FS_TSD_CYC,
  parameter int PWRD_CYC = sst_pkg::PWRD_CYC,
  parameter int TR_INIT_CYC = sst_pkg::TR_INIT_CYC,
  parameter int TR_INIT_LONG_CYC = sst_pkg::TR_INIT_LONG_CYC,
  parameter int TRDEL_STEP_CYC = sst_pkg::TRDEL_STEP_CYC,
  parameter int FORCE_SHORT_CYC = sst_pkg::FORCE_SHORT_CYC,
  parameter int FORCE_LONG_CYC = sst_pkg::FORCE_LONG_CYC,
  parameter int RECOVER_CYC = sst_pkg::RECOVER_CYC
) (
  input logic aclk,
  input logic aresetn,
  input logic [31:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [31:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input sst_pkg::sst_fault_t fault,
  input logic [N_CMP-1:0] comp_trip,
  input logic [N_CMP-1:0] safety_react,
  output logic [N_CMP-1:0] test_force_q,
  output logic self_test_active_q,
  output sst_pkg::sst_state_t dev_state_q,
  output logic irq_q
);

  localparam int TW = sst_pkg::TMR_W;
  localparam int IW = (N_CMP > 1) ? $clog2(N_CMP) : 1;
  localparam logic [IW-1:0] IDX_LAST = IW'(N_CMP - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic aw_hold_q, w_hold_q, wstrb0_q;
  logic [31:0] waddr_q, wdat_q;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire wr_do = aw_hold_q & w_hold_q & ~bvalid;
  wire aw_hold_n = ~wr_do & (aw_hold_q | aw_take);
  wire w_hold_n = ~wr_do & (w_hold_q | w_take);
  wire bvalid_n = wr_do | (bvalid & ~bready);
  wire rvalid_n = ar_take | (rvalid & ~rready);

  // Write decode on the held address
  wire wa_ctrl = waddr_q == sst_pkg::ADDR_TEST_CTRL;
  wire wa_cfg = waddr_q == sst_pkg::ADDR_DEV_CFG;
  wire wa_pick = waddr_q == sst_pkg::ADDR_PICK;
  wire wa_istat = waddr_q == sst_pkg::ADDR_IRQ_STAT;
  wire wa_imask = waddr_q == sst_pkg::ADDR_IRQ_MASK;
  wire wa_stat = waddr_q == sst_pkg::ADDR_STATUS;
  wire w_hit = wa_ctrl | wa_cfg | wa_pick | wa_istat | wa_imask | wa_stat;
  wire wr_lo = wr_do & wstrb0_q;
  wire w_ctrl = wr_lo & wa_ctrl;
  wire w_cfg = wr_lo & wa_cfg;
  wire w_pick = wr_lo & wa_pick;
  wire w_istat = wr_lo & wa_istat;
  wire w_imask = wr_lo & wa_imask;

  // Read decode
  wire ra_ctrl = araddr == sst_pkg::ADDR_TEST_CTRL;
  wire ra_cfg = araddr == sst_pkg::ADDR_DEV_CFG;
  wire ra_pick = araddr == sst_pkg::ADDR_PICK;
  wire ra_stat = araddr == sst_pkg::ADDR_STATUS;
  wire ra_istat = araddr == sst_pkg::ADDR_IRQ_STAT;
  wire ra_imask = araddr == sst_pkg::ADDR_IRQ_MASK;
  wire r_hit = ra_ctrl | ra_cfg | ra_pick | ra_stat | ra_istat | ra_imask;

  // Handshake; one write and one read in flight at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= sst_pkg::RESP_OKAY;
      waddr_q <= '0;
      wdat_q <= '0;
      wstrb0_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_n;
      w_hold_q <= w_hold_n;
      awready <= ~aw_hold_n & ~bvalid_n;
      wready <= ~w_hold_n & ~bvalid_n;
      bvalid <= bvalid_n;
      if (aw_take) begin
        waddr_q <= awaddr;
      end
      if (w_take) begin
        wdat_q <= wdata;
        wstrb0_q <= wstrb[0];
      end
      if (wr_do) begin
        bresp <= w_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [sst_pkg::TRDEL_W-1:0] trdel_q;
  sst_pkg::sst_req_t req_q;
  logic path_q, single_q, pass_q, pend_q;
  logic [N_CMP-1:0] pick_q, pick_clr;
  logic [sst_pkg::IRQ_W-1:0] istat_q, imask_q, ev;
  sst_pkg::sst_test_t tst_q, tst_d;
  sst_pkg::sst_state_t tgt_q;

  // Path and single bits only change between runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trdel_q <= sst_pkg::TRDEL_RST;
      req_q <= sst_pkg::REQ_STAY;
      path_q <= 1'b0;
      single_q <= 1'b0;
      imask_q <= sst_pkg::MASK_RST;
    end else begin
      if (w_cfg) begin
        trdel_q <= wdat_q[sst_pkg::TRDEL_LSB +: sst_pkg::TRDEL_W];
        req_q <= sst_pkg::sst_req_t'(wdat_q[sst_pkg::REQ_LSB +: 2]);
      end
      if (w_ctrl && tst_q == sst_pkg::TS_IDLE) begin
        path_q <= wdat_q[sst_pkg::PATH_BIT];
        single_q <= wdat_q[sst_pkg::SINGLE_BIT];
      end
      if (w_imask) begin
        imask_q <= wdat_q[sst_pkg::IRQ_W-1:0];
      end
    end
  end

  // Hardware owns the pick mask while a run is going
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pick_q <= sst_pkg::PICK_RST;
    end else if (tst_q != sst_pkg::TS_IDLE) begin
      pick_q <= pick_q & ~pick_clr;
    end else if (w_pick) begin
      pick_q <= wdat_q[N_CMP-1:0];
    end
  end

  // Sticky events: a new event wins over a same-cycle write-one-to-clear
  wire [sst_pkg::IRQ_W-1:0] iclr = w_istat ? wdat_q[sst_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~iclr) | ev;
      irq_q <= |(istat_q & imask_q);
    end
  end

  // Read data assembly
  logic [31:0] ctrl_rd, cfg_rd, stat_rd;
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[sst_pkg::GO_BIT] = self_test_active_q;
    ctrl_rd[sst_pkg::PATH_BIT] = path_q;
    ctrl_rd[sst_pkg::SINGLE_BIT] = single_q;
    ctrl_rd[sst_pkg::PASS_BIT] = pass_q;
    cfg_rd = '0;
    cfg_rd[sst_pkg::TRDEL_LSB +: sst_pkg::TRDEL_W] = trdel_q;
    cfg_rd[sst_pkg::REQ_LSB +: 2] = req_q;
    stat_rd = '0;
    stat_rd[sst_pkg::STATE_LSB +: 3] = dev_state_q;
    stat_rd[sst_pkg::PEND_BIT] = pend_q;
    stat_rd[sst_pkg::BUSY_BIT] = tst_q != sst_pkg::TS_IDLE;
  end

  wire [31:0] rd_data = ra_ctrl ? ctrl_rd :
                        ra_cfg ? cfg_rd :
                        ra_pick ? 32'(pick_q) :
                        ra_stat ? stat_rd :
                        ra_istat ? 32'(istat_q) :
                        ra_imask ? 32'(imask_q) : 32'h0000_0000;

  // Read channel answers on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= sst_pkg::RESP_OKAY;
    end else begin
      arready <= ~rvalid_n;
      rvalid <= rvalid_n;
      if (ar_take) begin
        rdata <= rd_data;
        rresp <= r_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog self-test sequencer

  logic [IW-1:0] idx_q, idx_d;
  logic go_d, pass_d, seen_q, seen_d, tt_load, tt_exp, ev_done, ev_fail;
  logic [N_CMP-1:0] force_d;
  logic [TW-1:0] tt_val;

  // Comparator-only watches the raw trip, full-path the safety reaction
  wire hit_now = path_q ? safety_react[idx_q] : comp_trip[idx_q];
  wire hit_any = seen_q | hit_now;
  wire idx_end = idx_q == IDX_LAST;

  always_comb begin
    tst_d = tst_q;
    idx_d = idx_q;
    go_d = self_test_active_q;
    pass_d = pass_q;
    seen_d = seen_q;
    force_d = test_force_q;
    pick_clr = '0;
    tt_load = 1'b0;
    tt_val = '0;
    ev_done = 1'b0;
    ev_fail = 1'b0;
    case (tst_q)
      sst_pkg::TS_IDLE: begin
        if (w_ctrl && wdat_q[sst_pkg::GO_BIT]) begin
          go_d = 1'b1;
          pass_d = 1'b1;
          idx_d = '0;
          tst_d = sst_pkg::TS_SEEK;
        end
      end
      sst_pkg::TS_SEEK: begin
        // Ascending index order; unpicked slots are skipped
        if (pick_q[idx_q]) begin
          tst_d = sst_pkg::TS_FORCE;
          force_d = N_CMP'(1) << idx_q;
          seen_d = 1'b0;
          tt_load = 1'b1;
          tt_val = path_q ? TW'(FORCE_LONG_CYC - 1) : TW'(FORCE_SHORT_CYC - 1);
        end else if (idx_end) begin
          tst_d = sst_pkg::TS_DONE;
        end else begin
          idx_d = idx_q + 1'b1;
        end
      end
      sst_pkg::TS_FORCE: begin
        seen_d = hit_any;
        if (tt_exp) begin
          force_d = '0;
          tt_load = 1'b1;
          tt_val = TW'(RECOVER_CYC - 1);
          tst_d = sst_pkg::TS_RECOVER;
          if (hit_any) begin
            pick_clr[idx_q] = 1'b1;
          end else begin
            pass_d = 1'b0;
          end
        end
      end
      sst_pkg::TS_RECOVER: begin
        // Let the comparator settle before the next one is forced
        if (tt_exp) begin
          if (single_q || idx_end) begin
            tst_d = sst_pkg::TS_DONE;
          end else begin
            idx_d = idx_q + 1'b1;
            tst_d = sst_pkg::TS_SEEK;
          end
        end
      end
      sst_pkg::TS_DONE: begin
        go_d = 1'b0;
        ev_done = 1'b1;
        ev_fail = ~pass_q;
        tst_d = sst_pkg::TS_IDLE;
      end
      default: begin
        tst_d = sst_pkg::TS_IDLE;
        force_d = '0;
        go_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tst_q <= sst_pkg::TS_IDLE;
      idx_q <= '0;
      self_test_active_q <= 1'b0;
      pass_q <= 1'b0;
      seen_q <= 1'b0;
      test_force_q <= '0;
    end else begin
      tst_q <= tst_d;
      idx_q <= idx_d;
      self_test_active_q <= go_d;
      pass_q <= pass_d;
      seen_q <= seen_d;
      test_force_q <= force_d;
    end
  end

  sst_timer #(.W(TW), .RST_VAL('0)) u_test_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tt_load),
    .value(tt_val),
    .expired(tt_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Device state machine

  sst_pkg::sst_state_t state_d, tgt_d;
  logic pend_d, st_load, st_exp, tr_load, tr_exp, ev_init_to, ev_tsd;
  logic [TW-1:0] st_val, tr_val;

  // Fault moves are held off while the self test drives artificial faults
  wire pd_cond = fault.vs_below_pd | fault.int_uv | fault.int_ov;
  wire in_fs = dev_state_q == sst_pkg::ST_FAILSAFE;
  wire flt_fs = fault.move_to_failsafe & ~self_test_active_q & ~in_fs;
  wire init_from = dev_state_q inside {sst_pkg::ST_NORMAL, sst_pkg::ST_SLEEP,
                                       sst_pkg::ST_STANDBY, sst_pkg::ST_WAKE};
  wire init_pend = pend_q & (tgt_q == sst_pkg::ST_INIT);
  wire flt_init = fault.move_to_init & ~self_test_active_q & init_from & ~init_pend;
  wire long_init = (dev_state_q == sst_pkg::ST_STANDBY) | pend_q;
  wire [TW-1:0] trdel_cyc = TW'((32'(trdel_q) + 32'd1) * 32'(TRDEL_STEP_CYC));

  always_comb begin
    state_d = dev_state_q;
    pend_d = pend_q;
    tgt_d = tgt_q;
    st_load = 1'b0;
    st_val = '0;
    tr_load = 1'b0;
    tr_val = '0;
    ev_init_to = 1'b0;
    ev_tsd = 1'b0;
    if (pd_cond) begin
      state_d = sst_pkg::ST_POWERDOWN;
      pend_d = 1'b0;
      st_load = 1'b1;
      st_val = TW'(PWRD_CYC - 1);
    end else if (fault.thermal_shutdown) begin
      // Held reloaded while hot, so the minimum counts from cool-down
      state_d = sst_pkg::ST_FAILSAFE;
      pend_d = 1'b0;
      st_load = 1'b1;
      st_val = TW'(FS_TSD_CYC);
      ev_tsd = ~in_fs;
    end else if (pend_q && tr_exp) begin
      state_d = tgt_q;
      pend_d = 1'b0;
      if (tgt_q == sst_pkg::ST_INIT) begin
        st_load = 1'b1;
        st_val = TW'(INIT_CYC - 1);
      end
    end else if (flt_fs && dev_state_q != sst_pkg::ST_POWERDOWN) begin
      state_d = sst_pkg::ST_FAILSAFE;
      pend_d = 1'b0;
      st_load = 1'b1;
      st_val = TW'(FS_CYC);
    end else if (flt_init) begin
      // An aborted sleep or standby entry takes the long init path
      tgt_d = sst_pkg::ST_INIT;
      pend_d = 1'b1;
      tr_load = 1'b1;
      tr_val = long_init ? TW'(TR_INIT_LONG_CYC - 1) : TW'(TR_INIT_CYC - 1);
    end else begin
      case (dev_state_q)
        sst_pkg::ST_POWERDOWN: begin
          if (st_exp) begin
            state_d = sst_pkg::ST_INIT;
            st_load = 1'b1;
            st_val = TW'(INIT_CYC - 1);
          end
        end
        sst_pkg::ST_INIT: begin
          if (st_exp) begin
            state_d = sst_pkg::ST_FAILSAFE;
            ev_init_to = 1'b1;
            st_load = 1'b1;
            st_val = TW'(FS_CYC);
          end else if (req_q == sst_pkg::REQ_NORMAL) begin
            state_d = sst_pkg::ST_NORMAL;
          end
        end
        sst_pkg::ST_NORMAL: begin
          if (!pend_q && (req_q == sst_pkg::REQ_SLEEP || req_q == sst_pkg::REQ_STANDBY)) begin
            pend_d = 1'b1;
            tgt_d = (req_q == sst_pkg::REQ_SLEEP) ? sst_pkg::ST_SLEEP : sst_pkg::ST_STANDBY;
            tr_load = 1'b1;
            tr_val = trdel_cyc;
          end
        end
        sst_pkg::ST_SLEEP: begin
          if (req_q == sst_pkg::REQ_NORMAL) begin
            state_d = sst_pkg::ST_WAKE;
          end
        end
        sst_pkg::ST_WAKE: begin
          if (req_q == sst_pkg::REQ_NORMAL) begin
            state_d = sst_pkg::ST_NORMAL;
          end
        end
        sst_pkg::ST_STANDBY, sst_pkg::ST_FAILSAFE: begin
          // Both leave through init on the long path
          if (!pend_q && (in_fs ? (st_exp && !fault.move_to_failsafe) : req_q == sst_pkg::REQ_NORMAL)) begin
            pend_d = 1'b1;
            tgt_d = sst_pkg::ST_INIT;
            tr_load = 1'b1;
            tr_val = TW'(TR_INIT_LONG_CYC - 1);
          end
        end
        default: begin
          state_d = sst_pkg::ST_POWERDOWN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_state_q <= sst_pkg::ST_POWERDOWN;
      pend_q <= 1'b0;
      tgt_q <= sst_pkg::ST_INIT;
    end else begin
      dev_state_q <= state_d;
      pend_q <= pend_d;
      tgt_q <= tgt_d;
    end
  end

  // Startup delay runs straight out of reset
  sst_timer #(.W(TW), .RST_VAL(TW'(PWRD_CYC - 1))) u_state_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(st_load),
    .value(st_val),
    .expired(st_exp)
  );

  sst_timer #(.W(TW), .RST_VAL('0)) u_trans_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tr_load),
    .value(tr_val),
    .expired(tr_exp)
  );

  // Event collection for the sticky status
  always_comb begin
    ev = '0;
    ev[sst_pkg::IRQ_TEST_DONE] = ev_done;
    ev[sst_pkg::IRQ_INIT_TO] = ev_init_to;
    ev[sst_pkg::IRQ_TEST_FAIL] = ev_fail;
    ev[sst_pkg::IRQ_TSD] = ev_tsd;
  end

endmodule // sst_top

// ### inc/sst_pkg.sv
package sst_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int INIT_TIME_MS = 600;
  localparam int INIT_CYC = INIT_TIME_MS * 1000 * CLK_MHZ;
  localparam int FS_TIME_MS = 20;
  localparam int FS_CYC = FS_TIME_MS * 1000 * CLK_MHZ;
  localparam int FS_TSD_TIME_MS = 1000;
  localparam int FS_TSD_CYC = FS_TSD_TIME_MS * 1000 * CLK_MHZ;
  localparam int TR_INIT_US = 150;
  localparam int TR_INIT_CYC = TR_INIT_US * CLK_MHZ;
  localparam int TR_INIT_LONG_US = 250;
  localparam int TR_INIT_LONG_CYC = TR_INIT_LONG_US * CLK_MHZ;
  localparam int PWRD_TIME_US = 400;
  localparam int PWRD_CYC = PWRD_TIME_US * CLK_MHZ;
  localparam int TRDEL_STEP_US = 1000;
  localparam int TRDEL_STEP_CYC = TRDEL_STEP_US * CLK_MHZ;
  localparam int DEGLITCH_CYC = 64;
  localparam int FORCE_SHORT_CYC = DEGLITCH_CYC / 2;
  localparam int FORCE_LONG_CYC = DEGLITCH_CYC * 2;
  localparam int RECOVER_CYC = 16;
  localparam int TMR_W = 28;

  // Comparators under self test
  localparam int N_CMP = 8;
  localparam int SSC_OV_WDG_IDX = 6;
  localparam int SSC_TOG_MON_IDX = 7;

  // Register byte addresses
  localparam logic [31:0] ADDR_TEST_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_DEV_CFG = 32'h0000_0004;
  localparam logic [31:0] ADDR_PICK = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0010;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_0014;

  // Field positions
  localparam int GO_BIT = 0;
  localparam int PATH_BIT = 1;
  localparam int SINGLE_BIT = 2;
  localparam int PASS_BIT = 3;
  localparam int TRDEL_LSB = 0;
  localparam int TRDEL_W = 3;
  localparam int REQ_LSB = 4;
  localparam int STATE_LSB = 0;
  localparam int PEND_BIT = 3;
  localparam int BUSY_BIT = 4;
  localparam int IRQ_TEST_DONE = 0;
  localparam int IRQ_INIT_TO = 1;
  localparam int IRQ_TEST_FAIL = 2;
  localparam int IRQ_TSD = 3;
  localparam int IRQ_W = 4;

  // Reset values
  localparam logic [TRDEL_W-1:0] TRDEL_RST = 3'h0;
  localparam logic [N_CMP-1:0] PICK_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_POWERDOWN, ST_INIT, ST_NORMAL, ST_SLEEP, ST_STANDBY, ST_WAKE, ST_FAILSAFE
  } sst_state_t;

  typedef enum logic [1:0] {REQ_STAY, REQ_NORMAL, REQ_SLEEP, REQ_STANDBY} sst_req_t;

  typedef enum logic [2:0] {TS_IDLE, TS_SEEK, TS_FORCE, TS_RECOVER, TS_DONE} sst_test_t;

  typedef struct packed {
    logic vs_below_pd;
    logic int_uv;
    logic int_ov;
    logic thermal_shutdown;
    logic move_to_init;
    logic move_to_failsafe;
  } sst_fault_t;

endpackage

// ### hw/sst_timer.sv
`timescale 1ns/1ps

// Down counter; expired while the count rests at zero
module sst_timer #(
  parameter int W = 28,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic aclk,
  input logic aresetn,
  input logic load,
  input logic [W-1:0] value,
  output logic expired
);

  logic [W-1:0] cnt_q;

  // Load wins over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= RST_VAL;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);

endmodule // sst_timer

// ### bench/sst_checker.sv
`timescale 1ns/1ps

// Port checks for sst_top
module sst_checker #(
  parameter int INIT_CYC = 200,
  parameter int FS_TSD_CYC = 300,
  parameter int TR_INIT_CYC = 10,
  parameter int FORCE_SHORT_CYC = 32,
  parameter int FORCE_LONG_CYC = 128
) (
  input logic aclk,
  input logic aresetn,
  input sst_pkg::sst_fault_t fault,
  input logic [7:0] test_force_q,
  input logic self_test_active_q,
  input sst_pkg::sst_state_t dev_state_q
);
  localparam int TR_MAX = TR_INIT_CYC + 2;
  logic pd;
  logic [15:0] frc_q, ini_q, tsd_q;
  assign pd = fault.vs_below_pd | fault.int_uv | fault.int_ov;
  // Force length, init dwell, cycles since cool-down; the last one saturates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frc_q <= 16'h0;
      ini_q <= 16'h0;
      tsd_q <= 16'hffff;
    end else begin
      frc_q <= (|test_force_q) ? frc_q + 16'h1 : 16'h0;
      ini_q <= (dev_state_q == sst_pkg::ST_INIT) ? ini_q + 16'h1 : 16'h0;
      tsd_q <= fault.thermal_shutdown ? 16'h0 : tsd_q + {15'h0, tsd_q != 16'hffff};
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_pd_first: assert property (pd |=> dev_state_q == sst_pkg::ST_POWERDOWN)
    else $error("power-down not entered");
  a_tsd_enter: assert property (fault.thermal_shutdown && !pd |=>
    dev_state_q inside {sst_pkg::ST_FAILSAFE, sst_pkg::ST_POWERDOWN}) else $error("failsafe not entered");
  a_tsd_hold: assert property ($past(dev_state_q) == sst_pkg::ST_FAILSAFE &&
    !(dev_state_q inside {sst_pkg::ST_FAILSAFE, sst_pkg::ST_POWERDOWN}) |-> tsd_q >= FS_TSD_CYC - 1)
    else $error("failsafe left early");
  a_force_len: assert property ($fell(|test_force_q) |->
    frc_q == FORCE_SHORT_CYC || frc_q == FORCE_LONG_CYC) else $error("force length wrong");
  a_force_one: assert property ($onehot0(test_force_q))
    else $error("several comparators forced");
  a_force_go: assert property (|test_force_q |-> self_test_active_q)
    else $error("force without go");
  a_init_limit: assert property (ini_q <= INIT_CYC + 1)
    else $error("init time-out missed");
  a_init_entry: assert property (fault.move_to_init && !pd && !self_test_active_q &&
    dev_state_q == sst_pkg::ST_SLEEP |-> ##[1:TR_MAX] dev_state_q == sst_pkg::ST_INIT)
    else $error("init entry late");
endmodule // sst_checker

bind sst_top sst_checker #(.INIT_CYC(INIT_CYC), .FS_TSD_CYC(FS_TSD_CYC), .TR_INIT_CYC(TR_INIT_CYC),
  .FORCE_SHORT_CYC(FORCE_SHORT_CYC), .FORCE_LONG_CYC(FORCE_LONG_CYC)) sst_checker_inst (.*);

// ### bench/sst_cmp_model.sv
`timescale 1ns/1ps

// Comparator bank that the self test forces from the far side
module sst_cmp_model #(
  parameter int DEGLITCH = 64
) (
  input logic aclk,
  input logic [7:0] test_force_q,
  input logic [7:0] broken,
  output logic [7:0] comp_trip,
  output logic [7:0] safety_react,
  output logic [31:0] order_q,
  output logic [7:0] react_n_q
);
  logic [7:0] hold_q;
  logic [3:0] idx;
  initial begin
    hold_q = 8'h0;
    order_q = 32'h0;
    react_n_q = 8'h0;
  end
  // A sound comparator trips while forced; a broken one stays silent
  assign comp_trip = test_force_q & ~broken;
  // Reaction only once the fault outlasts the deglitch filter
  assign safety_react = (hold_q >= 8'(DEGLITCH)) ? comp_trip : 8'h0;
  // Index of the forced comparator
  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (test_force_q[i]) begin
        idx = 4'(i);
      end
    end
  end
  // Log each forced index in nibbles and count reactions
  always @(posedge aclk) begin
    hold_q <= (|test_force_q) ? hold_q + {7'h0, hold_q != 8'hff} : 8'h0;
    if ((|test_force_q) && hold_q == 8'h0) begin
      order_q <= {order_q[27:0], idx};
    end
    if ((|safety_react) && hold_q == 8'(DEGLITCH)) begin
      react_n_q <= react_n_q + 8'h1;
    end
  end
endmodule // sst_cmp_model

// ### bench/tb.sv
`timescale 1ns/1ps

module tb;
  localparam int INIT_C = 200;
  localparam int TSD_C = 300;
  localparam int STEP_C = 20;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d, order_q;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] broken = 8'h0, comp_trip, safety_react, test_force_q, react_n_q;
  logic [1:0] bresp, rresp, rr;
  logic awready, wready, bvalid, arready, rvalid, irq_q, self_test_active_q;
  sst_pkg::sst_fault_t fault = 6'h00;
  sst_pkg::sst_state_t dev_state_q;
  int num_errors = 0, n_compared = 0, cyc = 0, t0;

  sst_top #(.INIT_CYC(INIT_C), .FS_CYC(50), .FS_TSD_CYC(TSD_C), .PWRD_CYC(20), .TR_INIT_CYC(10),
    .TR_INIT_LONG_CYC(16), .TRDEL_STEP_CYC(STEP_C)) sst_top_inst (.*);
  sst_cmp_model sst_cmp_model_inst (.*);

  // Clock and cycle count
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Elapsed cycles since t0 must lie in a window
  task automatic inr(input int lo, input int hi);
    chk(32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    chk(32'(bresp), 32'(sst_pkg::RESP_OKAY));
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  // Read, then compare the masked word
  task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    rr = rresp;
    rready <= 1'h0;
    @(posedge aclk);
    chk(d & m, e);
  endtask
  task automatic wait_st(input sst_pkg::sst_state_t s);
    int n;
    for (n = 0; n < 2000 && dev_state_q !== s; n++) @(posedge aclk);
    chk(32'(dev_state_q), 32'(s));
  endtask
  task automatic run_test(input logic [31:0] ctrl);
    int n;
    wr(sst_pkg::ADDR_TEST_CTRL, ctrl);
    rc(sst_pkg::ADDR_TEST_CTRL, 32'h1, 32'h1);
    for (n = 0; n < 2000 && self_test_active_q !== 1'h0; n++) @(posedge aclk);
  endtask
  task automatic give_verdict();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t0 = cyc;
    wait_st(sst_pkg::ST_INIT);
    inr(1, 100);
    t0 = cyc;
    rc(sst_pkg::ADDR_DEV_CFG, 32'hffffffff, 32'h0);
    rc(sst_pkg::ADDR_IRQ_MASK, 32'hffffffff, 32'h0);
    rc(32'h0000_0040, 32'hffffffff, 32'h0);
    chk(32'(rr), 32'(sst_pkg::RESP_SLVERR));
    wait_st(sst_pkg::ST_FAILSAFE);
    inr(INIT_C * 11 / 12, INIT_C * 13 / 12);
    rc(sst_pkg::ADDR_IRQ_STAT, 32'hf, 32'h2);
    wait_st(sst_pkg::ST_INIT);
    wr(sst_pkg::ADDR_DEV_CFG, 32'h10);
    wait_st(sst_pkg::ST_NORMAL);
    wr(sst_pkg::ADDR_IRQ_STAT, 32'h2);
    wr(sst_pkg::ADDR_IRQ_MASK, 32'hf);
    // Comparator-only run over four picks, one of them broken
    broken <= 8'h04;
    wr(sst_pkg::ADDR_PICK, 32'hc5);
    run_test(32'h1);
    rc(sst_pkg::ADDR_PICK, 32'hff, 32'h04);
    rc(sst_pkg::ADDR_TEST_CTRL, 32'h9, 32'h0);
    rc(sst_pkg::ADDR_IRQ_STAT, 32'hf, 32'h5);
    chk(32'(irq_q), 32'h1);
    chk(order_q, 32'h0000_0267);
    chk(32'(react_n_q), 32'h0);
    wr(sst_pkg::ADDR_IRQ_STAT, 32'h5);
    repeat (2) @(posedge aclk);
    chk(32'(irq_q), 32'h0);
    // Full-path run on a sound comparator, then mask the interrupt
    broken <= 8'h00;
    wr(sst_pkg::ADDR_PICK, 32'h04);
    run_test(32'h3);
    rc(sst_pkg::ADDR_PICK, 32'hff, 32'h0);
    rc(sst_pkg::ADDR_TEST_CTRL, 32'h9, 32'h8);
    chk(32'(react_n_q), 32'h1);
    chk(32'(irq_q), 32'h1);
    wr(sst_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq_q), 32'h0);
    rc(sst_pkg::ADDR_IRQ_STAT, 32'hf, 32'h1);
    wr(sst_pkg::ADDR_IRQ_STAT, 32'h1);
    // Sleep entry timed by setting 2, then move to init from sleep
    wait_st(sst_pkg::ST_NORMAL);
    t0 = cyc;
    wr(sst_pkg::ADDR_DEV_CFG, 32'h22);
    wait_st(sst_pkg::ST_SLEEP);
    inr(3 * STEP_C * 4 / 5, 3 * STEP_C * 6 / 5 + 4);
    fault.move_to_init <= 1'h1;
    t0 = cyc;
    wait_st(sst_pkg::ST_INIT);
    inr(1, 12);
    // Internal overvoltage beats thermal shutdown; then the shutdown hold
    fault <= 6'h0c;
    repeat (2) @(posedge aclk);
    chk(32'(dev_state_q), 32'(sst_pkg::ST_POWERDOWN));
    fault <= 6'h04;
    wait_st(sst_pkg::ST_FAILSAFE);
    fault <= 6'h00;
    t0 = cyc;
    wait_st(sst_pkg::ST_INIT);
    inr(TSD_C * 9 / 10, 2000);
    give_verdict();
  end

  // Watchdog; the sequence needs under 3000 cycles
  initial begin
    #40000;
    num_errors++;
    give_verdict();
  end
endmodule // tb
